//--- inc/hpt_pkg.sv
// Package for the hashed page table address generator: constants, types and field layout.
package hpt_pkg;

   // ----------------------------------------------------------------
   // Bus map
   // ----------------------------------------------------------------
   localparam logic [11:0] ADDR_DESC = 12'h000;
   localparam logic [11:0] ADDR_VA_LO = 12'h004;
   localparam logic [11:0] ADDR_VA_HI = 12'h008;
   localparam logic [11:0] ADDR_CTRL = 12'h00C;
   localparam logic [11:0] ADDR_STAT = 12'h010;
   localparam logic [11:0] ADDR_EADDR = 12'h014;
   localparam logic [11:0] ADDR_EHI = 12'h018;
   localparam logic [11:0] ADDR_ELO = 12'h01C;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] RST_DESC = 32'h0000_0000;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Field layout (little-endian bit numbers; big-endian bit k is 31-k)
   // ----------------------------------------------------------------
   localparam int ORG_LSB = 16;
   localparam int MASK_W = 9;
   localparam int HASH_W = 19;
   localparam int LOW_HASH_W = 10;
   localparam int GRP_ALIGN = 6;
   localparam int SLOTS = 8;
   localparam int SLOT_BYTES = 8;
   localparam int ENT_VALID = 31;
   localparam int ENT_HSEL = 6;
   localparam int ENT_API_LSB = 0;
   localparam int API_W = 6;
   localparam int VIRTUAL_SEGMENT_ID_W = 24;
   localparam int STAT_BUSY = 0;
   localparam int STAT_HIT = 1;
   localparam int STAT_FAULT = 2;
   localparam int STAT_SEC = 3;
   localparam int STAT_SLOT_LSB = 4;

   typedef enum logic [1:0] {
      HPT_RD_IDLE,
      HPT_RD_REQ,
      HPT_RD_WAIT
   } hpt_rd_t;

   typedef struct packed {
      logic [VIRTUAL_SEGMENT_ID_W-1:0] virtual_segment_id;
      logic [15:0] page_index;
   } hpt_vaddr_t;

   typedef struct packed {
      logic [31:0] hi;
      logic [31:0] lo;
   } hpt_entry_t;

endpackage : hpt_pkg

//--- verilog/hpt_addr_gen.sv
// Hashed page table search engine with an APB register port and a memory read port.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Sixteen candidate slots per virtual page.
// - Any of eight slots may hold entry.
// - Primary miss leads to secondary group search.
// - Secondary miss raises a page fault.
// - Hash operands: segment id, page index.
// - Primary hash is zero-extended index XOR segment.
// - Secondary hash inverts primary hash.
// - Index mask suppresses upper hash bits.
// - Bits 7-15: masked hash OR origin.
// - Bits 16-25: ten low hash bits.
// - Low six address bits are zero.
// - Upper address bits copy table origin.
// - At most eight entries per group.
// - Descriptor holds origin and index mask.
// - Entries stepped at 8-byte increments.
// - Hit needs valid, segment and page match.
// - Hash-select bit must match group kind.
module hpt_addr_gen (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic mem_req,
   output logic [31:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [63:0] mem_rdata,
   output logic fault_pulse,
   output logic hit_pulse
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0] table_descriptor_reg_ff;
   hpt_pkg::hpt_vaddr_t va_ff;
   logic busy_ff;
   logic hit_ff;
   logic fault_ff;
   logic sec_ff;
   logic [2:0] slot_ff;
   hpt_pkg::hpt_entry_t entry_ff;
   hpt_pkg::hpt_rd_t rd_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic mem_req_ff;
   logic [31:0] mem_addr_ff;
   logic fault_pulse_ff;
   logic hit_pulse_ff;

   // ----------------------------------------------------------------
   // Address generation
   // ----------------------------------------------------------------
   wire logic [15:0] table_origin = table_descriptor_reg_ff[31:hpt_pkg::ORG_LSB];
   wire logic [8:0] table_index_mask = table_descriptor_reg_ff[hpt_pkg::MASK_W-1:0];

   wire logic [18:0] seg_bits = va_ff.virtual_segment_id[hpt_pkg::HASH_W-1:0];
   wire logic [18:0] hash1 = seg_bits ^ {3'h0, va_ff.page_index};
   wire logic [18:0] hash_sel = sec_ff ? ~hash1 : hash1;

   // Forms an entry group address from origin, mask and hash.
   function automatic logic [31:0] grp_addr(input logic [15:0] org, input logic [8:0] msk,
                                             input logic [18:0] h);
      logic [31:0] a;
      a = 32'h0000_0000;
      a[31:25] = org[15:9];
      a[24:16] = (h[18:10] & msk) | org[8:0];
      a[15:6] = h[hpt_pkg::LOW_HASH_W-1:0];
      a[hpt_pkg::GRP_ALIGN-1:0] = 6'h00;
      return a;
   endfunction : grp_addr

   wire logic [31:0] group_base = grp_addr(table_origin, table_index_mask, hash_sel);
   wire logic [31:0] slot_addr = group_base | {26'h0, slot_ff, 3'h0};

   // ----------------------------------------------------------------
   // Entry compare
   // ----------------------------------------------------------------
   wire logic [31:0] ent_hi = mem_rdata[63:32];
   wire logic ent_hit = ent_hi[hpt_pkg::ENT_VALID]
      && ent_hi[30:7] == va_ff.virtual_segment_id
      && ent_hi[hpt_pkg::ENT_HSEL] == sec_ff
      && ent_hi[5:0] == va_ff.page_index[15:10];
   wire logic last_slot = slot_ff == 3'(hpt_pkg::SLOTS - 1);

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire logic acc = psel && penable && !pready_ff;
   // Writes land on the edge where the master sees pready high, never earlier.
   wire logic done = psel && penable && pready_ff;
   wire logic wr = done && pwrite;
   wire logic known = paddr <= hpt_pkg::ADDR_ELO && paddr[1:0] == 2'h0;
   wire logic start = wr && paddr == hpt_pkg::ADDR_CTRL && pwdata[0] && !busy_ff;
   wire logic [31:0] stat_word = {25'h0, slot_ff, sec_ff, fault_ff, hit_ff, busy_ff};
   wire logic [31:0] rd_mux =
      paddr == hpt_pkg::ADDR_DESC ? table_descriptor_reg_ff :
      paddr == hpt_pkg::ADDR_VA_LO ? {16'h0, va_ff.page_index} :
      paddr == hpt_pkg::ADDR_VA_HI ? {8'h0, va_ff.virtual_segment_id} :
      paddr == hpt_pkg::ADDR_STAT ? stat_word :
      paddr == hpt_pkg::ADDR_EADDR ? mem_addr_ff :
      paddr == hpt_pkg::ADDR_EHI ? entry_ff.hi :
      paddr == hpt_pkg::ADDR_ELO ? entry_ff.lo : 32'h0000_0000;

   // Read data is zero outside the ready cycle, so a stale word never lingers on the bus.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= hpt_pkg::RST_WORD;
      end else begin
         pready_ff <= acc;
         pslverr_ff <= acc && !known;
         prdata_ff <= acc && !pwrite ? rd_mux : hpt_pkg::RST_WORD;
      end
   end

   // Descriptor and address are frozen during a search so a group is never mixed.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         table_descriptor_reg_ff <= hpt_pkg::RST_DESC;
         va_ff <= '0;
      end else if (wr && !busy_ff) begin
         // Reserved descriptor bits are dropped on write so they always read zero.
         // descriptor fields
         if (paddr == hpt_pkg::ADDR_DESC) table_descriptor_reg_ff <= pwdata & 32'hFFFF_01FF;
         if (paddr == hpt_pkg::ADDR_VA_LO) va_ff.page_index <= pwdata[15:0];
         if (paddr == hpt_pkg::ADDR_VA_HI) va_ff.virtual_segment_id <= pwdata[23:0];
      end
   end

   // ----------------------------------------------------------------
   // Search sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_ff <= hpt_pkg::HPT_RD_IDLE;
         busy_ff <= 1'b0;
         hit_ff <= 1'b0;
         fault_ff <= 1'b0;
         sec_ff <= 1'b0;
         slot_ff <= 3'h0;
         mem_req_ff <= 1'b0;
         mem_addr_ff <= hpt_pkg::RST_WORD;
         entry_ff <= '0;
         hit_pulse_ff <= 1'b0;
         fault_pulse_ff <= 1'b0;
      end else begin
         hit_pulse_ff <= 1'b0;
         fault_pulse_ff <= 1'b0;
         unique case (rd_ff)
            hpt_pkg::HPT_RD_IDLE: begin
               if (start) begin
                  busy_ff <= 1'b1;
                  hit_ff <= 1'b0;
                  fault_ff <= 1'b0;
                  sec_ff <= 1'b0;
                  slot_ff <= 3'h0;
                  rd_ff <= hpt_pkg::HPT_RD_REQ;
               end
            end
            // The address is registered here so it stays put for the whole read.
            hpt_pkg::HPT_RD_REQ: begin
               mem_req_ff <= 1'b1;
               mem_addr_ff <= slot_addr;
               rd_ff <= hpt_pkg::HPT_RD_WAIT;
            end
            hpt_pkg::HPT_RD_WAIT: begin
               if (mem_ack) begin
                  mem_req_ff <= 1'b0;
                  if (ent_hit) begin
                     hit_ff <= 1'b1;
                     hit_pulse_ff <= 1'b1;
                     busy_ff <= 1'b0;
                     entry_ff <= mem_rdata;
                     rd_ff <= hpt_pkg::HPT_RD_IDLE;
                  end else if (!last_slot) begin
                     slot_ff <= slot_ff + 3'h1;
                     rd_ff <= hpt_pkg::HPT_RD_REQ;
                  end else if (!sec_ff) begin
                     sec_ff <= 1'b1;
                     slot_ff <= 3'h0;
                     rd_ff <= hpt_pkg::HPT_RD_REQ;
                  end else begin
                     fault_ff <= 1'b1;
                     fault_pulse_ff <= 1'b1;
                     busy_ff <= 1'b0;
                     rd_ff <= hpt_pkg::HPT_RD_IDLE;
                  end
               end
            end
            // Code three is never entered; fall back to idle rather than stay busy.
            default: begin
               busy_ff <= 1'b0;
               mem_req_ff <= 1'b0;
               rd_ff <= hpt_pkg::HPT_RD_IDLE;
            end
         endcase
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign mem_req = mem_req_ff;
   assign mem_addr = mem_addr_ff;
   assign hit_pulse = hit_pulse_ff;
   assign fault_pulse = fault_pulse_ff;

   // ----------------------------------------------------------------
   // Search bookkeeping
   // ----------------------------------------------------------------
   // Reads issued since the last start; it feeds only the assertions below.
   logic [4:0] reads_ff;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reads_ff <= 5'h00;
      end else if (start) begin
         reads_ff <= 5'h00;
      end else if (rd_ff == hpt_pkg::HPT_RD_REQ) begin
         reads_ff <= reads_ff + 5'h01;
      end
   end

   // Hash bits rebuilt from the raw operands, apart from the hash wires,
   // so a slip in the datapath cannot hide behind its own expression.
   wire logic [8:0] upper_hash_chk = va_ff.virtual_segment_id[18:10]
      ^ {3'h0, va_ff.page_index[15:10]} ^ {9{sec_ff}};
   wire logic [9:0] low_hash_chk = va_ff.virtual_segment_id[9:0] ^ va_ff.page_index[9:0];
   wire logic [4:0] read_limit = 5'(2 * hpt_pkg::SLOTS);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_last_miss;
      rd_ff == hpt_pkg::HPT_RD_WAIT && mem_ack && !ent_hit && last_slot;
   endsequence

   a_addr_align: assert property (@(posedge mclk) disable iff (rst)
      mem_req |-> mem_addr[5:0] == {slot_ff, 3'h0}) else $error("group address misaligned");
   a_upper_origin: assert property (@(posedge mclk) disable iff (rst)
      mem_req |-> mem_addr[31:25] == table_origin[15:9]) else $error("upper origin lost");
   a_low_hash: assert property (@(posedge mclk) disable iff (rst)
      mem_req |-> mem_addr[15:6] == (sec_ff ? ~hash1[9:0] : hash1[9:0]))
      else $error("low hash bits wrong");
   a_mask_merge: assert property (@(posedge mclk) disable iff (rst)
      mem_req |-> mem_addr[24:16]
         == ((upper_hash_chk & table_descriptor_reg_ff[8:0]) | table_descriptor_reg_ff[24:16]))
      else $error("masked hash merge wrong");
   a_second_group: assert property (@(posedge mclk) disable iff (rst)
      s_last_miss and !sec_ff |=> sec_ff && slot_ff == 3'h0) else $error("secondary not taken");
   a_fault_raise: assert property (@(posedge mclk) disable iff (rst)
      s_last_miss and sec_ff |=> fault_pulse && fault_ff && !busy_ff) else $error("fault missing");
   a_hit_stop: assert property (@(posedge mclk) disable iff (rst)
      rd_ff == hpt_pkg::HPT_RD_WAIT && mem_ack && ent_hit |=> hit_pulse && !busy_ff && !mem_req)
      else $error("search not stopped on hit");
   a_slot_step: assert property (@(posedge mclk) disable iff (rst)
      rd_ff == hpt_pkg::HPT_RD_WAIT && mem_ack && !ent_hit && !last_slot
      |=> ##1 mem_addr == $past(mem_addr, 2) + 32'h8) else $error("slot stride wrong");
   a_sec_hsel: assert property (@(posedge mclk) disable iff (rst)
      hit_pulse |-> entry_ff.hi[hpt_pkg::ENT_HSEL] == sec_ff) else $error("hash-select mismatch");
   a_entry_valid: assert property (@(posedge mclk) disable iff (rst)
      hit_pulse |-> entry_ff.hi[hpt_pkg::ENT_VALID]) else $error("invalid entry taken as hit");

   sequence s_read_open;
      mem_req && !mem_ack;
   endsequence

   sequence s_read_close;
      mem_req && mem_ack;
   endsequence

   a_hash_primary: assert property (@(posedge mclk) disable iff (rst)
      mem_req && !sec_ff |-> mem_addr[15:6] == low_hash_chk) else $error("primary hash wrong");
   a_hash_invert: assert property (@(posedge mclk) disable iff (rst)
      mem_req && sec_ff |-> mem_addr[15:6] == ~low_hash_chk)
      else $error("secondary hash not inverted");
   a_mask_off: assert property (@(posedge mclk) disable iff (rst)
      mem_req && table_index_mask == 9'h000 |-> mem_addr[24:16] == table_origin[8:0])
      else $error("masked hash bits leaked");
   a_req_hold: assert property (@(posedge mclk) disable iff (rst)
      s_read_open |=> mem_req && $stable(mem_addr)) else $error("read request dropped early");
   a_one_read: assert property (@(posedge mclk) disable iff (rst)
      s_read_close |=> !mem_req) else $error("read left open after data");
   a_idle_quiet: assert property (@(posedge mclk) disable iff (rst)
      !busy_ff |-> !mem_req) else $error("read issued while idle");
   a_read_budget: assert property (@(posedge mclk) disable iff (rst)
      busy_ff |-> reads_ff <= read_limit) else $error("too many entries read");
   a_fault_count: assert property (@(posedge mclk) disable iff (rst)
      fault_pulse |-> reads_ff == read_limit) else $error("fault before all slots read");
   a_hit_count: assert property (@(posedge mclk) disable iff (rst)
      hit_pulse |-> reads_ff == {1'b0, sec_ff, slot_ff} + 5'h01) else $error("search ran past hit");
   a_primary_first: assert property (@(posedge mclk) disable iff (rst)
      start |=> busy_ff && !sec_ff && slot_ff == 3'h0) else $error("search did not open in primary");
   a_busy_freeze: assert property (@(posedge mclk) disable iff (rst)
      busy_ff |=> $stable(table_descriptor_reg_ff) && $stable(va_ff))
      else $error("descriptor changed during search");
   a_desc_reserved: assert property (@(posedge mclk) disable iff (rst)
      table_descriptor_reg_ff[15:9] == 7'h00) else $error("reserved descriptor bits set");
   a_pulse_excl: assert property (@(posedge mclk) disable iff (rst)
      !(hit_pulse && fault_pulse)) else $error("hit and fault together");

   // ----------------------------------------------------------------
   // Register port checks
   // ----------------------------------------------------------------
   a_ready_pulse: assert property (@(posedge mclk) disable iff (rst)
      pready |=> !pready) else $error("ready held past one cycle");
   a_err_ready: assert property (@(posedge mclk) disable iff (rst)
      pslverr |-> pready) else $error("error without ready");
   a_rdata_idle: assert property (@(posedge mclk) disable iff (rst)
      !pready |-> prdata == 32'h0000_0000) else $error("read data outside ready cycle");

endmodule : hpt_addr_gen
`default_nettype wire

//--- dv/hpt_mem_model.sv
// Main memory model holding the page table entries read by the search engine.
`timescale 1ns/1ps
`default_nettype none
module hpt_mem_model (
   input wire logic mclk,
   input wire logic mem_req,
   input wire logic [31:0] mem_addr,
   output logic mem_ack,
   output logic [63:0] mem_rdata
);
   logic [63:0] store [logic [31:0]];
   logic [31:0] log_q[$];
   int lat = 0;
   int wait_cnt = 0;
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 64'h0;
   end
   // Read data is only meaningful in the ack cycle, so it toggles otherwise.
   always @(posedge mclk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req === 1'b1 && mem_ack !== 1'b1) begin
         if (wait_cnt < lat) begin
            wait_cnt <= wait_cnt + 1;
         end else begin
            wait_cnt <= 0;
            mem_ack <= 1'b1;
            log_q.push_back(mem_addr);
            mem_rdata <= store.exists(mem_addr) ? store[mem_addr] : 64'h7FFF_FFFF_FFFF_FFFF;
         end
      end
   end
endmodule : hpt_mem_model
`default_nettype wire

//--- dv/hpt_addr_gen_bench.sv
// Self-checking bench for the hashed page table search engine.
`timescale 1ns/1ps
`default_nettype none
module hpt_addr_gen_bench;
   logic mclk, rst, psel, penable, pwrite, pready, pslverr, mem_req, mem_ack, err;
   logic fault_pulse, hit_pulse;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, mem_addr, rd, d, g;
   logic [63:0] mem_rdata, e;
   logic [23:0] vs;
   logic [15:0] pi;
   int mismatches = 0;
   int total_checks = 0;
   int cyc = 0;
   hpt_addr_gen hpt_addr_gen_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .fault_pulse(fault_pulse), .hit_pulse(hit_pulse));
   hpt_mem_model hpt_mem_model_i (.mclk(mclk), .mem_req(mem_req), .mem_addr(mem_addr),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   // A hang anywhere ends the run as a failure.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         finish_test();
      end
   end
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dat);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= dat;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb
   function automatic logic [31:0] grp(input logic [31:0] ds, input logic [23:0] v,
                                       input logic [15:0] p, input logic sec);
      logic [18:0] h;
      h = v[18:0] ^ {3'b000, p};
      if (sec) h = ~h;
      return {ds[31:25], (h[18:10] & ds[8:0]) | ds[24:16], h[9:0], 6'h00};
   endfunction : grp
   function automatic logic [63:0] ent(input logic [23:0] v, input logic [15:0] p,
                                       input logic h);
      return {1'b1, v, h, p[15:10], 32'h1234_5678};
   endfunction : ent
   task automatic search(input logic [31:0] ds, input int n, input logic hit);
      int k;
      hpt_mem_model_i.log_q.delete();
      apb(1'b1, hpt_pkg::ADDR_DESC, ds);
      apb(1'b1, hpt_pkg::ADDR_VA_HI, {8'h00, vs});
      apb(1'b1, hpt_pkg::ADDR_VA_LO, {16'h0000, pi});
      apb(1'b1, hpt_pkg::ADDR_CTRL, 32'h0000_0001);
      k = 0;
      while (hit_pulse !== 1'b1 && fault_pulse !== 1'b1 && k < 400) begin
         @(posedge mclk);
         k++;
      end
      check(hit_pulse, hit);
      check(fault_pulse, !hit);
      check(hpt_mem_model_i.log_q.size(), n);
      for (k = 0; k < n; k++) begin
         check(hpt_mem_model_i.log_q[k], grp(ds, vs, pi, k > 7) + 8 * (k % 8));
      end
      @(posedge mclk);
      apb(1'b0, hpt_pkg::ADDR_STAT, 32'h0);
      if (hit) check(rd[6:0], {3'((n - 1) % 8), n > 8, 3'b010});
      else check(rd[2:0], 3'b100);
      $display("search done after %0d reads", n);
   endtask : search
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      apb(1'b0, hpt_pkg::ADDR_DESC, 32'h0);
      check(rd, hpt_pkg::RST_DESC);
      apb(1'b0, 12'h020, 32'h0);
      check(err, 1'b1);
      check(rd, 32'h0);
      apb(1'b1, hpt_pkg::ADDR_DESC, 32'hFFFF_FFFF);
      apb(1'b0, hpt_pkg::ADDR_DESC, 32'h0);
      check(rd, 32'hFFFF_01FF);
      $display("register test done");
      d = 32'h0F98_0003;
      vs = 24'h5A_1234;
      pi = 16'hC3A7;
      g = grp(d, vs, pi, 1'b0);
      e = ent(vs, pi, 1'b0);
      hpt_mem_model_i.store[g + 8] = ent(vs, pi ^ 16'h0400, 1'b0);
      hpt_mem_model_i.store[g + 16] = ent(vs, pi, 1'b1);
      hpt_mem_model_i.store[g + 24] = {1'b0, e[62:0]};
      hpt_mem_model_i.store[g + 40] = e;
      search(d, 6, 1'b1);
      apb(1'b0, hpt_pkg::ADDR_EADDR, 32'h0);
      check(rd, g + 40);
      apb(1'b0, hpt_pkg::ADDR_EHI, 32'h0);
      check(rd, e[63:32]);
      apb(1'b0, hpt_pkg::ADDR_ELO, 32'h0);
      check(rd, e[31:0]);
      hpt_mem_model_i.store.delete();
      hpt_mem_model_i.lat = 3;
      hpt_mem_model_i.store[g + 8] = ent(vs, pi, 1'b1);
      hpt_mem_model_i.store[grp(d, vs, pi, 1'b1)] = ent(vs, pi, 1'b1);
      search(d, 9, 1'b1);
      hpt_mem_model_i.store.delete();
      hpt_mem_model_i.lat = 0;
      vs = 24'h00_7F00;
      pi = 16'h1234;
      search(32'hA5C3_0000, 16, 1'b0);
      search(32'hA5C0_0003, 16, 1'b0);
      search(32'hA400_01FF, 16, 1'b0);
      hpt_mem_model_i.lat = 3;
      apb(1'b1, hpt_pkg::ADDR_CTRL, 32'h0000_0001);
      apb(1'b1, hpt_pkg::ADDR_DESC, 32'h0000_0000);
      apb(1'b0, hpt_pkg::ADDR_STAT, 32'h0);
      check(rd[0], 1'b1);
      apb(1'b0, hpt_pkg::ADDR_DESC, 32'h0);
      check(rd, 32'hA400_01FF);
      $display("busy refusal test done");
      finish_test();
   end
endmodule : hpt_addr_gen_bench
`default_nettype wire
